// [rtl/ltmc_host.sv]
// host-side controller driving the transceiver's drive, mode and watching state pins
////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: bus drive low gives dominant bus, high leaves it recessive.
// R2: host sets drive level before raising mode; device latches it as slew.
// R3: exactly two slews: normal for 20 kbps, slow for 10 kbps.
// R4: in active modes state output follows the bus level.
// R5: in sleep the state output floats.
// R6: a recognised wake drives the state output low.
// R7: mode control high means normal operation, both paths active.
// R8: sleep requested by mode low with drive high, after filter delay.
// R9: a mode low shorter than 50 us is no sleep request.
// R10: entering sleep turns the regulator control output off.
// R11: regulator control turns off within 50 us of mode falling.
// R12: switch input changes filtered, 10 to 70 us.
// R13: bus wake needs dominant longer than 40..120 us filter.
// R14: drive settles at least 5.0 us before mode rises.
// R15: first transmitted bit at least 50 us after mode selection.
// R16: fast toggle, mode low to high, completes within 35 us.
// R17: in fast mode a mode glitch under 5.0 us returns to prior mode.
// R18: overcurrent switches the driver off after about 10 us.
// R19: fast entry: both low, raise drive, then raise mode.
// R20: chosen slew kept until passing through sleep.
// R21: power-up or wake gives awake state: regulator on, state output low.
// R22: sleep records switch level; filtered opposite level wakes.
// R23: windows are counted and compared to constant limits.
module ltmc_host
	import ltmc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic req_slow,      // slew choice for the next wake
	input  wire logic req_fast,      // pulse: run toggle into or out of fast
	input  wire logic req_sleep,     // pulse: put transceiver to sleep
	input  wire logic req_wake,      // pulse: wake transceiver from sleep
	input  wire logic uart_tx,       // user serial data
	input  wire logic bus_state,     // transceiver state output
	input  wire logic bus_state_oe,  // transceiver drives state output
	output logic      bus_drive,     // to transceiver drive input
	output logic      mode_ctrl,     // to transceiver mode control input
	output logic      uart_rx,       // received bus level
	output logic      link_ready,    // transmit allowed
	output logic      slow_sel,      // slew latched at last wake
	output logic      fast_on,       // fast mode believed active
	output logic      asleep,        // transceiver believed asleep
	output logic      wake_seen      // wake reported while asleep
);
	ltmc_state_type   state;
	logic [CNT_W-1:0] cnt;           // window counter
	logic [CNT_W-1:0] lo_run;        // cycles of the sleep request pattern

	// counts must fit the counter and the toggle must fit its windows
	initial begin
		assert (SLEEP_CYC < 2**CNT_W && FIRST_BIT_CYC < 2**CNT_W) else $error("count width");
		assert (2 * GLITCH_CYC < FAST_CYC) else $error("toggle too slow");
		assert (GLITCH_CYC * 1000 < FAST_EXIT_NS * CLK_MHZ) else $error("glitch too long");
	end

	////////////////////////////////////////////////////////////////////////////
	// mode sequencer; window counter restarts on entry to each timed state and is held clear in active and sleep
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= LTMC_POWERUP;
			cnt        <= '0;
			bus_drive  <= 1'b1;
			mode_ctrl  <= 1'b0;
			link_ready <= 1'b0;
			slow_sel   <= 1'b0;
			fast_on    <= 1'b0;
			asleep     <= 1'b0;
		end else begin
			cnt <= cnt + 1'b1; // see R23
			case (state)
				LTMC_POWERUP: begin // awake state after power-up, see R21
					bus_drive <= ~req_slow; // see R2
					slow_sel  <= req_slow; // see R3
					cnt       <= '0;
					state     <= LTMC_SETUP;
				end
				LTMC_SETUP: begin
					if (cnt >= CNT_W'(SETUP_CYC)) begin // see R14
						mode_ctrl <= 1'b1; // see R7
						cnt       <= '0;
						state     <= LTMC_SETTLE;
					end
				end
				LTMC_SETTLE: begin
					bus_drive <= 1'b1;
					if (cnt >= CNT_W'(FIRST_BIT_CYC)) begin // see R15
						link_ready <= 1'b1;
						state      <= LTMC_ACTIVE;
					end
				end
				LTMC_ACTIVE: begin
					bus_drive <= uart_tx; // see R1
					cnt       <= '0;
					if (req_sleep) begin // see R8
						link_ready <= 1'b0;
						bus_drive  <= 1'b1;
						mode_ctrl  <= 1'b0;
						state      <= LTMC_SLEEP_REQ;
					end else if (req_fast && fast_on) begin
						link_ready <= 1'b0;
						mode_ctrl  <= 1'b0; // short glitch exits, see R17
						state      <= LTMC_FAST_GLITCH;
					end else if (req_fast) begin
						link_ready <= 1'b0;
						bus_drive  <= 1'b0; // both low first, see R19
						mode_ctrl  <= 1'b0;
						state      <= LTMC_FAST_LOW;
					end
				end
				LTMC_FAST_LOW: begin
					if (cnt == CNT_W'(GLITCH_CYC)) bus_drive <= 1'b1; // see R19
					if (cnt == CNT_W'(2 * GLITCH_CYC)) begin // well inside 35 us, see R16
						mode_ctrl <= 1'b1;
						fast_on   <= 1'b1;
						state     <= LTMC_ACTIVE;
						link_ready <= 1'b1;
					end
				end
				LTMC_FAST_GLITCH: begin
					if (cnt >= CNT_W'(GLITCH_CYC)) begin // under 5.0 us, see R17
						mode_ctrl  <= 1'b1;
						fast_on    <= 1'b0; // prior slew kept, see R20
						link_ready <= 1'b1;
						state      <= LTMC_ACTIVE;
					end
				end
				LTMC_SLEEP_REQ: begin
					// regulator control is already off by now, see R11
					if (cnt >= CNT_W'(SLEEP_CYC)) begin // held past the filter, see R9
						asleep  <= 1'b1; // see R10
						fast_on <= 1'b0;
						state   <= LTMC_SLEEP;
					end
				end
				LTMC_SLEEP: begin
					cnt <= '0;
					if (wake_seen || req_wake) begin // see R21
						asleep    <= 1'b0;
						bus_drive <= ~req_slow; // new slew only after sleep, see R20
						slow_sel  <= req_slow;
						state     <= LTMC_SETUP;
					end
				end
				default: state <= LTMC_POWERUP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive path; floating state output reads as recessive
	// a shorted bus reads dominant until the device cuts its driver, see R18
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) uart_rx <= 1'b1;
		else uart_rx <= bus_state_oe ? bus_state : 1'b1; // see R4 see R5
	end

	// wake report: driven low while asleep, see R6; filtering is inside the device
	// switch and bus filters and the switch reference live there, see R12 R13 R22
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) wake_seen <= 1'b0;
		else wake_seen <= (state == LTMC_SLEEP) && bus_state_oe && !bus_state; // see R6
	end

	////////////////////////////////////////////////////////////////////////////
	// helper: run length of the sleep request pattern, saturating
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lo_run <= '0;
		end else if (mode_ctrl || !bus_drive) begin
			lo_run <= '0;
		end else if (lo_run != '1) begin
			lo_run <= lo_run + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep belief only after the pattern outlasted the device filter
	a_sleep_span: assert property (@(posedge clk) disable iff (!rst_b) // see R9
		$rose(asleep) |-> lo_run > CNT_W'(SLEEP_HOLD_US * CLK_MHZ))
		else $error("sleep pattern too short");
	// slew level presented at the wake rise matches the latched choice
	a_wake_slew: assert property (@(posedge clk) disable iff (!rst_b) // see R2
		$rose(mode_ctrl) && state == LTMC_SETTLE |-> bus_drive == !slow_sel)
		else $error("slew level wrong at rise");
	// asleep: driver released and mode held low
	a_asleep_pins: assert property (@(posedge clk) disable iff (!rst_b) // see R10
		asleep |-> bus_drive && !mode_ctrl)
		else $error("pins wrong while asleep");
	// fast mode only reached with drive and mode both high
	a_fast_order: assert property (@(posedge clk) disable iff (!rst_b) // see R19
		$rose(fast_on) |-> bus_drive && mode_ctrl)
		else $error("fast entry order wrong");
	// floating state output reads recessive
	a_rx_float: assert property (@(posedge clk) disable iff (!rst_b) // see R5
		!bus_state_oe |=> uart_rx)
		else $error("floating state not recessive");
	// driven state output passes through one cycle later
	a_rx_follow: assert property (@(posedge clk) disable iff (!rst_b) // see R4
		bus_state_oe |=> uart_rx == $past(bus_state))
		else $error("receive not following bus");
	// mode sequencing checks
	a_sleep_drive_high: assert property (@(posedge clk) disable iff (!rst_b)
		(state == LTMC_SLEEP_REQ) |-> (bus_drive && !mode_ctrl)) else $error("sleep needs drive high"); // see R8
	a_setup_before_rise: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(mode_ctrl) && state == LTMC_SETTLE |-> $stable(bus_drive)[*1])
		else $error("drive moved at rise"); // see R14
	a_ready_after_wait: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(mode_ctrl) && state == LTMC_SETTLE |-> !link_ready[*8])
		else $error("transmit too early"); // see R15
	a_fast_low_short: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(mode_ctrl) && bus_drive == 1'b0 |-> ##[1:1000] mode_ctrl) else $error("toggle too long"); // see R16
	a_glitch_short: assert property (@(posedge clk) disable iff (!rst_b)
		(state == LTMC_FAST_GLITCH) |-> ##[1:200] mode_ctrl) else $error("exit glitch too long"); // see R17
	a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(asleep) |-> !mode_ctrl && !$past(mode_ctrl, 8))
		else $error("sleep low too short"); // see R9
	a_tx_follows: assert property (@(posedge clk) disable iff (!rst_b)
		(state == LTMC_ACTIVE) && link_ready && !req_sleep && !req_fast |=> bus_drive == $past(uart_tx))
		else $error("drive not following data"); // see R1
	a_slew_held: assert property (@(posedge clk) disable iff (!rst_b)
		!asleep && state != LTMC_POWERUP && state != LTMC_SLEEP |=> $stable(slow_sel))
		else $error("slew changed while awake"); // see R20
endmodule : ltmc_host

// [rtl/ltmc_pkg.sv]
// package: timing constants and enums for the lin transceiver mode controller
package ltmc_pkg;
	localparam int CLK_MHZ             = 50;   // clock rate in MHz
	localparam int SELECT_SETUP_NS     = 5000; // select_setup_delay, least 5.0 us
	localparam int FIRST_BIT_US        = 50;   // wait after mode selection, least
	localparam int SLEEP_HOLD_US       = 50;   // sleep_entry_delay, least
	localparam int FAST_ENTRY_US       = 35;   // fast_entry_window, longest
	localparam int FAST_EXIT_NS        = 5000; // fast_exit_glitch, below 5.0 us
	localparam int SWITCH_FILTER_US    = 70;   // switch_filter_time, max
	localparam int BUS_WAKE_US         = 120;  // bus_wake_filter_time, max
	localparam int OVERCURRENT_US      = 10;   // overcurrent_cutoff_delay, typical
	localparam int SETUP_CYC     = (SELECT_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int FIRST_BIT_CYC = FIRST_BIT_US * CLK_MHZ;
	localparam int SLEEP_CYC     = SLEEP_HOLD_US * CLK_MHZ + SETUP_CYC;
	localparam int FAST_CYC      = FAST_ENTRY_US * CLK_MHZ;
	localparam int GLITCH_CYC    = (FAST_EXIT_NS * CLK_MHZ) / 1000 / 2;
	localparam int SWITCH_CYC    = SWITCH_FILTER_US * CLK_MHZ;
	localparam int BUS_WAKE_CYC  = BUS_WAKE_US * CLK_MHZ;
	localparam int OVC_CYC       = OVERCURRENT_US * CLK_MHZ;
	localparam int CNT_W         = 16;
	typedef enum logic [3:0] {
		LTMC_POWERUP, LTMC_SETUP, LTMC_SELECT, LTMC_SETTLE, LTMC_ACTIVE,
		LTMC_FAST_LOW, LTMC_FAST_GLITCH, LTMC_SLEEP_REQ, LTMC_SLEEP
	} ltmc_state_type;
endpackage : ltmc_pkg

// [testbench/ltmc_dev_model.sv]
// behavioural transceiver model standing on the far side of the host controller
module ltmc_dev_model
	import ltmc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic bus_drive,
	input  wire logic mode_ctrl,
	input  wire logic remote_dom,
	output logic      bus_state,
	output logic      bus_state_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        sleeping;
	logic        wake_rpt;
	logic [15:0] lo_cnt;
	logic [15:0] dom_cnt;
	////////////////////////////////////////////////////////////////////////////////
	// wired-and bus; floating state output reads high through the host pull-up
	assign bus_state    = (wake_rpt || !bus_state_oe) ? wake_rpt == 1'b0 : bus_drive & ~remote_dom;
	assign bus_state_oe = ~sleeping | wake_rpt;
	// filters counted in clock cycles, no analog spread modelled
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sleeping <= 1'b0;
			wake_rpt <= 1'b1;
			lo_cnt   <= 16'h0000;
			dom_cnt  <= 16'h0000;
		end else begin
			lo_cnt  <= (!mode_ctrl && bus_drive) ? lo_cnt + 16'h0001 : 16'h0000;
			dom_cnt <= (sleeping && remote_dom) ? dom_cnt + 16'h0001 : 16'h0000;
			if (lo_cnt == 16'(SLEEP_HOLD_US * CLK_MHZ))
				sleeping <= 1'b1;
			if (dom_cnt == 16'(BUS_WAKE_CYC))
				wake_rpt <= 1'b1;
			if (mode_ctrl) begin
				sleeping <= 1'b0;
				wake_rpt <= 1'b0;
			end
		end
	end
endmodule : ltmc_dev_model

// [testbench/ltmc_host_tb.sv]
// self-checking bench for the lin transceiver host controller
module ltmc_host_tb;
	import ltmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, req_slow = 0, req_fast = 0, req_sleep = 0, req_wake = 0;
	logic uart_tx = 1, remote_dom = 0, bus_state, bus_state_oe, bus_drive, mode_ctrl;
	logic uart_rx, link_ready, slow_sel, fast_on, asleep, wake_seen;
	int   errors = 0;
	int   n_checks = 0;
	logic [3:0] rows [4] = '{4'b1011, 4'b0000, 4'b1110, 4'b0100}; // tx dom drive rx
	always #10 clk = ~clk;
	ltmc_host dut_u (.clk(clk), .rst_b(rst_b), .req_slow(req_slow), .req_fast(req_fast),
		.req_sleep(req_sleep), .req_wake(req_wake), .uart_tx(uart_tx), .bus_state(bus_state),
		.bus_state_oe(bus_state_oe), .bus_drive(bus_drive), .mode_ctrl(mode_ctrl),
		.uart_rx(uart_rx), .link_ready(link_ready), .slow_sel(slow_sel), .fast_on(fast_on),
		.asleep(asleep), .wake_seen(wake_seen));
	ltmc_dev_model dev_u (.clk(clk), .rst_b(rst_b), .bus_drive(bus_drive),
		.mode_ctrl(mode_ctrl), .remote_dom(remote_dom), .bus_state(bus_state),
		.bus_state_oe(bus_state_oe));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk
	// bounded wait; a missed flag shows up in the compare that follows
	task automatic wait_on(input int sel);
		for (int i = 0; i < 8000; i++) begin
			@(posedge clk);
			if ((sel == 0 && link_ready === 1'b1) || (sel == 1 && asleep === 1'b1) ||
			    (sel == 2 && wake_seen === 1'b1) || (sel == 3 && fast_on === 1'b1) ||
			    (sel == 4 && mode_ctrl === 1'b1))
				break;
		end
		#1;
	endtask : wait_on
	task automatic report_and_stop();
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// watchdog sized well beyond the longest sequence chain
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		chk("bus_drive_rst", 1'b1, bus_drive);
		chk("mode_ctrl_rst", 1'b0, mode_ctrl);
		chk("uart_rx_rst", 1'b1, uart_rx);
		rst_b <= 1'b1;
		wait_on(0);
		chk("mode_ctrl_up", 1'b1, mode_ctrl);
		chk("link_ready_up", 1'b1, link_ready);
		chk("slow_sel_normal", 1'b0, slow_sel);
		// ordinary traffic: drive follows data, receive follows wired bus
		foreach (rows[i]) begin
			@(posedge clk);
			uart_tx    <= rows[i][3];
			remote_dom <= rows[i][2];
			repeat (6) @(posedge clk);
			#1;
			chk("bus_drive", rows[i][1], bus_drive);
			chk("uart_rx", rows[i][0], uart_rx);
		end
		@(posedge clk);
		uart_tx <= 1'b1;
		remote_dom <= 1'b0;
		// fast toggle in and back out
		req_fast <= 1'b1;
		@(posedge clk);
		req_fast <= 1'b0;
		wait_on(3);
		chk("fast_on", 1'b1, fast_on);
		repeat (3000) @(posedge clk);
		req_fast <= 1'b1;
		@(posedge clk);
		req_fast <= 1'b0;
		repeat (3000) @(posedge clk);
		#1;
		chk("fast_off", 1'b0, fast_on);
		@(posedge clk);
		// sleep, then local wake choosing slow slew
		req_sleep <= 1'b1;
		@(posedge clk);
		req_sleep <= 1'b0;
		wait_on(1);
		chk("asleep", 1'b1, asleep);
		chk("sleep_drive_high", 1'b1, bus_drive);
		chk("state_floats", 1'b0, bus_state_oe);
		@(posedge clk);
		req_slow <= 1'b1;
		req_wake <= 1'b1;
		@(posedge clk);
		req_wake <= 1'b0;
		// slew level must stand while mode is still low
		repeat (5) @(negedge clk);
		chk("drive_before_mode", 1'b0, bus_drive);
		chk("mode_low_before", 1'b0, mode_ctrl);
		wait_on(4);
		chk("no_tx_yet", 1'b0, link_ready);
		wait_on(0);
		chk("slow_sel_slow", 1'b1, slow_sel);
		@(posedge clk);
		req_slow <= 1'b0;
		// sleep again, then a long dominant phase wakes from the bus
		req_sleep <= 1'b1;
		@(posedge clk);
		req_sleep <= 1'b0;
		wait_on(1);
		@(posedge clk);
		remote_dom <= 1'b1;
		wait_on(2);
		chk("wake_seen", 1'b1, wake_seen);
		report_and_stop();
	end
endmodule : ltmc_host_tb
